// *** design/iex_core.sv ***
// Instruction execute unit for rotates, moves, bits, skips, branches and power control.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module iex_core (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Program memory.
  output logic      [9:0]  pm_addr_o,
  input  wire logic [14:0] pm_data_i,
  // Power state.
  output logic             halted_o,
  output logic             sleep_o
);

  // All state of the core apart from the reset synchronizer and the data memory.
  typedef struct packed {
    iex_pkg::iex_state_type state;
    logic [9:0]             pc;
    logic [9:0]             pma;
    logic [7:0]             acc;
    logic                   c;
    logic                   to;
    logic                   powerdown_flag;
    logic [6:0]             table_high_latch;
    logic [7:0]             tblp;
    logic [6:0]             tbl_m;
    logic [3:0][9:0]        stk;
    logic [1:0]             sp;
    logic [7:0]             pre;
    logic [7:0]             wdt;
    logic [1:0]             wprev;
    logic                   run;
    logic                   idle;
    logic                   bus_wr;
    logic [7:0]             bus_a;
    logic [31:0]            rdata;
  } iex_regs_type;

  iex_regs_type r_reg;
  iex_regs_type r_next;

  logic                 rst_meta_reg, rst_n_reg, dm_we, exec, tick, wdt_exp, skip, wr;
  logic [6:0]           dm_wa, ins_m;
  logic [7:0]           dm_wd, dm_rd, imm, opnd, bmask, incv, decv, res;
  iex_pkg::iex_op_type  op;
  logic [8:0]           rotv;
  logic [9:0]           pc1;

  // One-bit rotate; the carry joins the ring only when asked, result in bits 7:0, carry out in bit 8.
  function automatic logic [8:0] rot9(input logic [7:0] d, input logic ci, input logic left, input logic thru);
    logic fill;
    fill = thru ? ci : (left ? d[7] : d[0]);
    rot9 = left ? {d[7], d[6:0], fill} : {d[0], fill, d[7:1]};
  endfunction

  // Reset is released through two flip-flops; everything else uses the copy.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // Field decode of the word on the program bus.
  assign op    = iex_pkg::iex_op_type'(pm_data_i[14:10]);
  assign ins_m = pm_data_i[6:0];
  assign imm   = pm_data_i[7:0];
  assign bmask = 8'h01 << pm_data_i[9:7];
  // The program counter low byte reads in place of its data address.
  assign opnd  = (ins_m == iex_pkg::PCL_ADDR) ? r_reg.pc[7:0] : dm_rd;
  assign incv  = opnd + 8'h01;
  assign decv  = opnd - 8'h01;
  assign rotv  = rot9(opnd, r_reg.c, pm_data_i[9], pm_data_i[8]);
  assign pc1   = r_reg.pc + 10'h001;
  assign exec  = (r_reg.state == iex_pkg::ST_RUN) && r_reg.run;
  assign tick  = r_reg.run && (r_reg.pre == iex_pkg::WDT_TICK_LAST);
  assign wdt_exp = tick && (r_reg.wdt == iex_pkg::WDT_LAST);

  // Next-state logic: bus, watchdog count, execution, then watchdog expiry.
  always_comb begin
    r_next = r_reg;
    dm_we  = 1'b0;
    dm_wa  = ins_m;
    dm_wd  = 8'h00;
    skip   = 1'b0;
    wr     = 1'b0;
    res    = opnd;

    // Data phase of a bus write.
    if (r_reg.bus_wr) begin
      unique case (r_reg.bus_a)
        iex_pkg::REG_CTRL: begin
          r_next.run  = hwdata_i[iex_pkg::CTRL_RUN_BIT];
          r_next.idle = hwdata_i[iex_pkg::CTRL_IDLE_BIT];
          if (hwdata_i[iex_pkg::CTRL_WAKE_BIT] && r_reg.state == iex_pkg::ST_HALT) begin
            r_next.state = iex_pkg::ST_RUN;
          end
        end
        iex_pkg::REG_ACC:  r_next.acc  = hwdata_i[7:0];
        iex_pkg::REG_TBLP: r_next.tblp = hwdata_i[7:0];
        default: ;
      endcase
    end

    // Address phase; read data is sampled now and stands in the data phase.
    r_next.bus_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      r_next.bus_wr = hwrite_i;
      r_next.bus_a  = haddr_i[7:0];
      r_next.rdata  = 32'h0000_0000;
      if (!hwrite_i) begin
        unique case (haddr_i[7:0])
          iex_pkg::REG_CTRL:   r_next.rdata = {29'h0, r_reg.idle, 1'b0, r_reg.run};
          iex_pkg::REG_STATUS: r_next.rdata = {28'h0, r_reg.state == iex_pkg::ST_HALT, r_reg.powerdown_flag, r_reg.to, r_reg.c};
          iex_pkg::REG_ACC:    r_next.rdata = {24'h0, r_reg.acc};
          iex_pkg::REG_PC:     r_next.rdata = {22'h0, r_reg.pc};
          iex_pkg::REG_TBLP:   r_next.rdata = {24'h0, r_reg.tblp};
          iex_pkg::REG_TABLE_HIGH_LATCH:   r_next.rdata = {25'h0, r_reg.table_high_latch};
          default: ;
        endcase
      end
    end

    // Watchdog prescaler and counter; keep counting while halted too.
    if (r_reg.run) begin
      r_next.pre = tick ? 8'h00 : r_reg.pre + 8'h01;
      if (tick) begin
        r_next.wdt = r_reg.wdt + 8'h01;
      end
    end

    // The discarded fetch slot changes nothing.
    if (r_reg.state == iex_pkg::ST_DUMMY) begin
      r_next.state = iex_pkg::ST_RUN;
    end

    // Second cycle of a table read: high part to the latch, low byte to memory.
    if (r_reg.state == iex_pkg::ST_TBL) begin
      r_next.table_high_latch  = pm_data_i[14:8];
      dm_we        = 1'b1;
      dm_wa        = r_reg.tbl_m;
      dm_wd        = pm_data_i[7:0];
      r_next.state = iex_pkg::ST_RUN;
    end

    // Execute the word at the program counter.
    if (exec) begin
      r_next.pc    = pc1;
      r_next.wprev = 2'h0;
      unique case (op)
        iex_pkg::OP_ROT: begin
          if (pm_data_i[8]) begin
            r_next.c = rotv[8];
          end
          if (pm_data_i[7]) begin
            r_next.acc = rotv[7:0];
          end else begin
            wr  = 1'b1;
            res = rotv[7:0];
          end
        end
        iex_pkg::OP_MOVAM: r_next.acc = opnd;
        iex_pkg::OP_MOVMA: begin
          wr  = 1'b1;
          res = r_reg.acc;
        end
        iex_pkg::OP_MOVAX: r_next.acc = imm;
        iex_pkg::OP_CLRB, iex_pkg::OP_SETB: begin
          wr  = 1'b1;
          res = (op == iex_pkg::OP_SETB) ? (opnd | bmask) : (opnd & ~bmask);
        end
        iex_pkg::OP_JMP: begin
          r_next.pc    = pm_data_i[9:0];
          r_next.state = iex_pkg::ST_DUMMY;
        end
        iex_pkg::OP_SZ:   skip = (opnd == 8'h00);
        iex_pkg::OP_SZA: begin
          r_next.acc = opnd;
          skip       = (opnd == 8'h00);
        end
        iex_pkg::OP_SZB:  skip = ((opnd & bmask) == 8'h00);
        iex_pkg::OP_SNZB: skip = ((opnd & bmask) != 8'h00);
        iex_pkg::OP_SIZ: begin
          wr   = 1'b1;
          res  = incv;
          skip = (incv == 8'h00);
        end
        iex_pkg::OP_SDZ: begin
          wr   = 1'b1;
          res  = decv;
          skip = (decv == 8'h00);
        end
        iex_pkg::OP_INC_SKIP_ZERO_TO_ACC: begin
          r_next.acc = incv;
          skip       = (incv == 8'h00);
        end
        iex_pkg::OP_DEC_SKIP_ZERO_TO_ACC: begin
          r_next.acc = decv;
          skip       = (decv == 8'h00);
        end
        iex_pkg::OP_CALL: begin
          r_next.stk[r_reg.sp] = pc1;
          r_next.sp            = r_reg.sp + 2'h1;
          r_next.pc            = pm_data_i[9:0];
          r_next.state         = iex_pkg::ST_DUMMY;
        end
        iex_pkg::OP_RET, iex_pkg::OP_RETURN_FROM_INTERRUPT: begin
          r_next.sp    = r_reg.sp - 2'h1;
          r_next.pc    = r_reg.stk[r_reg.sp - 2'h1];
          r_next.state = iex_pkg::ST_DUMMY;
        end
        iex_pkg::OP_RETAX: begin
          r_next.sp    = r_reg.sp - 2'h1;
          r_next.pc    = r_reg.stk[r_reg.sp - 2'h1];
          r_next.acc   = imm;
          r_next.state = iex_pkg::ST_DUMMY;
        end
        iex_pkg::OP_TBRC, iex_pkg::OP_TBRL: begin
          r_next.tbl_m = ins_m;
          r_next.pma   = {(op == iex_pkg::OP_TBRL) ? iex_pkg::PAGE_LAST : r_reg.pc[9:8], r_reg.tblp};
          r_next.state = iex_pkg::ST_TBL;
        end
        iex_pkg::OP_CLRM, iex_pkg::OP_SETM: begin
          wr  = 1'b1;
          res = (op == iex_pkg::OP_SETM) ? 8'hFF : 8'h00;
        end
        iex_pkg::OP_WDT: begin
          // A pre-clear acts only right after its partner; a repeat does nothing.
          r_next.wprev = pm_data_i[1:0];
          if (pm_data_i[1:0] == iex_pkg::WDT_SINGLE ||
              (pm_data_i[1:0] == iex_pkg::WDT_FIRST && r_reg.wprev == iex_pkg::WDT_SECOND) ||
              (pm_data_i[1:0] == iex_pkg::WDT_SECOND && r_reg.wprev == iex_pkg::WDT_FIRST)) begin
            r_next.to  = 1'b0;
            r_next.powerdown_flag = 1'b0;
            r_next.wdt = 8'h00;
            r_next.pre = 8'h00;
          end
        end
        iex_pkg::OP_SWAP: begin
          wr  = 1'b1;
          res = {opnd[3:0], opnd[7:4]};
        end
        iex_pkg::OP_NIBBLE_EXCHANGE_TO_ACC: r_next.acc = {opnd[3:0], opnd[7:4]};
        iex_pkg::OP_HALT: begin
          r_next.to    = 1'b0;
          r_next.powerdown_flag   = 1'b1;
          r_next.wdt   = 8'h00;
          r_next.pre   = 8'h00;
          r_next.state = iex_pkg::ST_HALT;
        end
        default: ;
      endcase

      // A met skip steps over the next word and spends its slot as a dummy.
      if (skip) begin
        r_next.pc    = r_reg.pc + 10'h002;
        r_next.state = iex_pkg::ST_DUMMY;
      end

      // A write to the counter low byte redirects the program and flushes.
      if (wr) begin
        if (ins_m == iex_pkg::PCL_ADDR) begin
          r_next.pc    = {r_reg.pc[9:8], res};
          r_next.state = iex_pkg::ST_DUMMY;
        end else begin
          dm_we = 1'b1;
          dm_wd = res;
        end
      end
    end

    // Expiry wins over any clear in the same cycle; it wakes or restarts.
    if (wdt_exp) begin
      r_next.to  = 1'b1;
      r_next.wdt = 8'h00;
      if (r_reg.state == iex_pkg::ST_HALT) begin
        r_next.state = iex_pkg::ST_RUN;
      end else begin
        r_next.pc    = 10'h000;
        r_next.sp    = 2'h0;
        r_next.state = iex_pkg::ST_DUMMY;
      end
    end

    // The program address follows the counter except during a table read.
    if (r_next.state != iex_pkg::ST_TBL) begin
      r_next.pma = r_next.pc;
    end
  end

  // State register.
  always_ff @(posedge mclk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Data memory.
  iex_dmem u_dmem (
    .clk_i   (mclk_i),
    .we_i    (dm_we),
    .waddr_i (dm_wa),
    .wdata_i (dm_wd),
    .raddr_i (ins_m),
    .rdata_o (dm_rd)
  );

  // Outputs; the slave never waits and never errors.
  assign hrdata_o    = r_reg.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign pm_addr_o   = r_reg.pma;
  assign halted_o    = (r_reg.state == iex_pkg::ST_HALT);
  assign sleep_o     = halted_o && !r_reg.idle;

  // Checks on the execution behaviour.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_reg);

  a_rot_plain_carry: assert property (exec && op == iex_pkg::OP_ROT && !pm_data_i[8] && !r_reg.bus_wr
    |=> r_reg.c == $past(r_reg.c)) else $error("plain rotate changed carry");
  a_rot_carry_ring: assert property (exec && op == iex_pkg::OP_ROT && pm_data_i[8] && !pm_data_i[9]
    |=> r_reg.c == $past(opnd[0])) else $error("right carry rotate lost bit 0");
  a_mov_imm_acc: assert property (exec && op == iex_pkg::OP_MOVAX
    |=> r_reg.acc == $past(imm)) else $error("immediate not loaded");
  a_jump_two_cycle: assert property (exec && op == iex_pkg::OP_JMP && !wdt_exp
    |=> r_reg.state == iex_pkg::ST_DUMMY && r_reg.pc == $past(pm_data_i[9:0])
    ##1 r_reg.state == iex_pkg::ST_RUN) else $error("jump timing or target wrong");
  a_call_push_next: assert property (exec && op == iex_pkg::OP_CALL && !wdt_exp
    |=> r_reg.stk[$past(r_reg.sp)] == $past(pc1) && r_reg.sp == $past(r_reg.sp) + 2'h1)
    else $error("call pushed wrong address");
  a_skip_met_two: assert property (exec && skip && !wr && !wdt_exp
    |=> r_reg.state == iex_pkg::ST_DUMMY && r_reg.pc == $past(r_reg.pc) + 10'h002)
    else $error("met skip did not take two cycles");
  a_skip_miss_one: assert property (exec && !skip && !wdt_exp && (op == iex_pkg::OP_SZ || op == iex_pkg::OP_SZB)
    |=> r_reg.state == iex_pkg::ST_RUN) else $error("missed skip took extra cycle");
  a_pcl_write_flush: assert property (exec && wr && ins_m == iex_pkg::PCL_ADDR && !wdt_exp
    |=> r_reg.state == iex_pkg::ST_DUMMY && r_reg.pc[7:0] == $past(res)) else $error("low counter write not two cycles");
  a_dummy_quiet: assert property (r_reg.state == iex_pkg::ST_DUMMY
    |-> !dm_we && (r_next.acc == r_reg.acc || (r_reg.bus_wr && r_reg.bus_a == iex_pkg::REG_ACC)))
    else $error("dummy cycle changed state");
  a_halt_flags: assert property (exec && op == iex_pkg::OP_HALT && !wdt_exp
    |=> halted_o && r_reg.powerdown_flag && !r_reg.to && r_reg.wdt == 8'h00) else $error("power-down entry wrong");
  a_wdt_single_clr: assert property (exec && op == iex_pkg::OP_WDT && pm_data_i[1:0] == iex_pkg::WDT_SINGLE
    && !wdt_exp |=> !r_reg.to && !r_reg.powerdown_flag) else $error("watchdog clear missed flags");
  a_wdt_pair_hold: assert property (exec && op == iex_pkg::OP_WDT && pm_data_i[1:0] == iex_pkg::WDT_FIRST
    && r_reg.wprev != iex_pkg::WDT_SECOND && !wdt_exp |=> r_reg.to == $past(r_reg.to)
    && r_reg.powerdown_flag == $past(r_reg.powerdown_flag)) else $error("unpaired pre-clear changed flags");

endmodule

// *** design/iex_dmem.sv ***
// Data memory of the execute unit: combinational read, clocked write.
`timescale 1ns/1ps
module iex_dmem (
  // Clock.
  input  wire logic       clk_i,
  // Write port.
  input  wire logic       we_i,
  input  wire logic [6:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // Read port.
  input  wire logic [6:0] raddr_i,
  output logic      [7:0] rdata_o
);

  // Contents are kept across power-down; no reset, as in a real RAM.
  logic [7:0] mem [0:iex_pkg::DM_DEPTH-1];

  // Write on the clock edge.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read is asynchronous so an operand is ready in its own cycle.
  assign rdata_o = mem[raddr_i];

endmodule

// *** design/iex_pkg.sv ***
// Package with constants and types of the instruction execute unit.
package iex_pkg;

  // Program counter width and data memory depth of the core.
  localparam int PC_W     = 10;
  localparam int DM_DEPTH = 128;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ACC    = 8'h08;
  localparam logic [7:0] REG_PC     = 8'h0C;
  localparam logic [7:0] REG_TBLP   = 8'h10;
  localparam logic [7:0] REG_TABLE_HIGH_LATCH   = 8'h14;

  // Field positions.
  localparam int CTRL_RUN_BIT  = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_IDLE_BIT = 2;
  localparam int ST_C_BIT      = 0;
  localparam int ST_TO_BIT     = 1;
  localparam int ST_PDF_BIT    = 2;
  localparam int ST_HALT_BIT   = 3;

  // Data address that stands for the low byte of the program counter.
  localparam logic [6:0] PCL_ADDR  = 7'h02;
  // Upper program counter bits of the final program page.
  localparam logic [1:0] PAGE_LAST = 2'h3;

  // Watchdog timing: one tick per period, expiry after the last tick.
  localparam int         CLK_NS        = 10;
  localparam int         WDT_TICK_NS   = 2560;
  localparam int         WDT_TICK_CYC  = WDT_TICK_NS / CLK_NS;
  localparam logic [7:0] WDT_TICK_LAST = 8'(WDT_TICK_CYC - 1);
  localparam logic [7:0] WDT_LAST      = 8'hFF;

  // Sub-codes of the watchdog instruction.
  localparam logic [1:0] WDT_SINGLE = 2'h0;
  localparam logic [1:0] WDT_FIRST  = 2'h1;
  localparam logic [1:0] WDT_SECOND = 2'h2;

  // Execution states, Gray coded along run, dummy, table.
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_DUMMY = 2'h1,
    ST_TBL   = 2'h3,
    ST_HALT  = 2'h2
  } iex_state_type;

  // Operation field, bits 14 to 10 of the instruction word.
  typedef enum logic [4:0] {
    OP_NOP   = 5'h00, OP_ROT   = 5'h01, OP_MOVAM = 5'h02, OP_MOVMA = 5'h03,
    OP_MOVAX = 5'h04, OP_CLRB  = 5'h05, OP_SETB  = 5'h06, OP_JMP   = 5'h07,
    OP_SZ    = 5'h08, OP_SZA   = 5'h09, OP_SZB   = 5'h0A, OP_SNZB  = 5'h0B,
    OP_SIZ   = 5'h0C, OP_SDZ   = 5'h0D, OP_INC_SKIP_ZERO_TO_ACC  = 5'h0E, OP_DEC_SKIP_ZERO_TO_ACC  = 5'h0F,
    OP_CALL  = 5'h10, OP_RET   = 5'h11, OP_RETAX = 5'h12, OP_RETURN_FROM_INTERRUPT  = 5'h13,
    OP_TBRC  = 5'h14, OP_TBRL  = 5'h15, OP_CLRM  = 5'h16, OP_SETM  = 5'h17,
    OP_WDT   = 5'h18, OP_SWAP  = 5'h19, OP_NIBBLE_EXCHANGE_TO_ACC = 5'h1A, OP_HALT  = 5'h1B
  } iex_op_type;

endpackage

// *** sim/iex_pmem_model.sv ***
// Program memory model that answers the execute unit's fetch address.
`timescale 1ns/1ps
module iex_pmem_model (
  // Fetch address from the core.
  input  wire logic [9:0]  addr_i,
  // Program word back to the core.
  output logic      [14:0] data_o
);
  logic [14:0] mem [0:1023];

  // The read is combinational, because the core takes the word in the cycle of its address.
  assign data_o = mem[addr_i];
endmodule

// *** sim/mcu_instruction_execute_subset_tb.sv ***
// Bench of the execute unit: programs in the model memory, results read over AHB-Lite.
`timescale 1ns/1ps
module mcu_instruction_execute_subset_tb;
  logic        mclk_i   = 1'b0;
  logic        resetn_i = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [31:0] hwdata   = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [9:0]  pm_addr;
  logic [14:0] pm_data;
  logic        halted;
  logic        sleep;
  logic [31:0] rd;
  logic [31:0] seed     = 32'h5CF586EB;
  int          fail_count  = 0;
  int          checks_done = 0;

  // Free-running system clock of 10 ns.
  always #5 mclk_i = ~mclk_i;

  iex_core dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .pm_addr_o(pm_addr), .pm_data_i(pm_data),
    .halted_o(halted), .sleep_o(sleep)
  );

  iex_pmem_model u_pm (
    .addr_i(pm_addr),
    .data_o(pm_data)
  );

  // Maximal-length shift register step for repeatable operands.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected rotate result as {carry, byte}; vr is {left, through carry, to acc}.
  function automatic logic [8:0] rot_ref(input logic [7:0] v, input logic [2:0] vr, input logic c);
    case (vr[2:1])
      2'h3:    return {v[7], v[6:0], c};
      2'h2:    return {c, v[6:0], v[7]};
      2'h1:    return {v[0], c, v[7:1]};
      default: return {c, v[0], v[7:1]};
    endcase
  endfunction

  // Verdict and end of the run.
  task automatic stop_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Comparison with case equality so an unknown never matches.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Stores one instruction word in the model memory.
  task automatic put(input int a, input iex_pkg::iex_op_type op, input logic [9:0] opd);
    u_pm.mem[a] = {op, opd};
  endtask

  // Reset for four cycles with the memory cleared to no-ops, then the allowed settling edges.
  task automatic boot;
    resetn_i <= 1'b0;
    for (int i = 0; i < 1024; i++) begin
      u_pm.mem[i] = 15'h0000;
    end
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
  endtask

  // One single AHB-Lite word transfer; the address phase is held until hready is seen high.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wr ? d : ~d;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Starts the core and counts instruction cycles up to and including the power-down.
  task automatic run(input int cyc);
    int n;
    n = 0;
    bus(1'b1, iex_pkg::REG_CTRL, 32'h1);
    do begin
      @(posedge mclk_i);
      n++;
      #1;
    end while (halted !== 1'b1 && n < 200);
    check("cycles", n, cyc);
  endtask

  // A hang is cut short at twenty thousand cycles, far beyond the four hundred or so that the tests need.
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  // Main sequence: register file, rotates, skips and branches, calls and tables, watchdog pairs.
  initial begin
    logic [7:0]  v;
    logic [6:0]  m;
    logic [6:0]  m2;
    logic [8:0]  r1;
    logic [8:0]  r2;
    logic [14:0] wt;
    boot();
    bus(1'b0, iex_pkg::REG_STATUS, 32'h0);
    check("status_reset", rd, 32'h0);
    bus(1'b1, iex_pkg::REG_ACC, {24'h0, seed[7:0]});
    bus(1'b0, iex_pkg::REG_ACC, 32'h0);
    check("acc_rw", rd, {24'h0, seed[7:0]});
    bus(1'b1, iex_pkg::REG_STATUS, 32'hF);
    bus(1'b0, iex_pkg::REG_STATUS, 32'h0);
    check("status_ro", rd, 32'h0);
    bus(1'b0, 8'h18, 32'h0);
    check("unmapped", rd, 32'h0);
    // Every rotate variant twice in a row, so the second one sees the carry of the first.
    for (int k = 0; k < 8; k++) begin
      boot();
      seed = lfsr(seed);
      v = seed[7:0];
      m = {2'h1, seed[12:8]};
      put(0, iex_pkg::OP_MOVAX, {2'h0, v});
      put(1, iex_pkg::OP_MOVMA, {3'h0, m});
      put(2, iex_pkg::OP_ROT, {3'(k), m});
      put(3, iex_pkg::OP_ROT, {3'(k), m});
      put(4, k[0] ? iex_pkg::OP_NOP : iex_pkg::OP_MOVAM, {3'h0, m});
      put(5, iex_pkg::OP_HALT, 10'h000);
      r1 = rot_ref(v, 3'(k), 1'b0);
      r2 = rot_ref(k[0] ? v : r1[7:0], 3'(k), r1[8]);
      run(6);
      bus(1'b0, iex_pkg::REG_ACC, 32'h0);
      check("rot_acc", rd, {24'h0, r2[7:0]});
      bus(1'b0, iex_pkg::REG_STATUS, 32'h0);
      check("rot_carry", rd[0], r2[8]);
    end
    // Program counter low write, met and missed skips, and a jump over dead code.
    boot();
    m = {2'h1, seed[20:16]};
    put(0, iex_pkg::OP_MOVAX, 10'h004);
    put(1, iex_pkg::OP_MOVMA, {3'h0, iex_pkg::PCL_ADDR});
    put(2, iex_pkg::OP_MOVAX, 10'h077);
    put(4, iex_pkg::OP_MOVAX, 10'h000);
    put(5, iex_pkg::OP_MOVMA, {3'h0, m});
    put(6, iex_pkg::OP_SZ, {3'h0, m});
    put(7, iex_pkg::OP_MOVAX, 10'h011);
    put(8, iex_pkg::OP_SIZ, {3'h0, m});
    put(9, iex_pkg::OP_MOVAX, 10'h022);
    put(10, iex_pkg::OP_SDZ, {3'h0, m});
    put(11, iex_pkg::OP_MOVAX, 10'h033);
    put(12, iex_pkg::OP_SZB, {3'h0, m});
    put(13, iex_pkg::OP_MOVAX, 10'h044);
    put(14, iex_pkg::OP_SETB, {3'h7, m});
    put(15, iex_pkg::OP_SNZB, {3'h7, m});
    put(16, iex_pkg::OP_MOVAX, 10'h055);
    put(17, iex_pkg::OP_SZA, {3'h0, m});
    put(18, iex_pkg::OP_JMP, 10'd24);
    put(19, iex_pkg::OP_MOVAX, 10'h066);
    put(24, iex_pkg::OP_HALT, 10'h000);
    run(20);
    bus(1'b0, iex_pkg::REG_ACC, 32'h0);
    check("skip_acc", rd, 32'h80);
    // Call, watchdog clear, return, last-page table read and nibble exchange.
    boot();
    seed = lfsr(seed);
    wt = seed[14:0];
    m = {2'h1, seed[20:16]};
    bus(1'b1, iex_pkg::REG_TBLP, {24'h0, seed[31:24]});
    u_pm.mem[{2'h3, seed[31:24]}] = wt;
    put(0, iex_pkg::OP_CALL, 10'd8);
    put(1, iex_pkg::OP_TBRL, {3'h0, m});
    put(2, iex_pkg::OP_SWAP, {3'h0, m});
    put(3, iex_pkg::OP_MOVAM, {3'h0, m});
    put(4, iex_pkg::OP_HALT, 10'h000);
    put(8, iex_pkg::OP_WDT, {8'h0, iex_pkg::WDT_SINGLE});
    put(9, iex_pkg::OP_RET, 10'h000);
    run(10);
    bus(1'b0, iex_pkg::REG_ACC, 32'h0);
    check("table_swap", rd, {24'h0, wt[3:0], wt[7:4]});
    bus(1'b0, iex_pkg::REG_TABLE_HIGH_LATCH, 32'h0);
    check("table_high", rd, {25'h0, wt[14:8]});
    bus(1'b0, iex_pkg::REG_STATUS, 32'h0);
    check("halt_flags", rd[3:1], 3'h6);
    check("sleep", sleep, 1'b1);
    bus(1'b1, iex_pkg::REG_CTRL, 32'h5);
    @(posedge mclk_i); // The write lands at the edge that ends the task, so look one cycle later.
    check("idle", {halted, sleep}, 2'h2);
    // Accumulator skips, bit and byte writes, nibble exchange to acc, current-page table, interrupt return.
    boot();
    seed = lfsr(seed);
    m  = {2'h1, seed[4:0]};
    m2 = {2'h2, seed[20:16]};
    wt = seed[30:16];
    bus(1'b1, iex_pkg::REG_TBLP, {24'h0, 1'b1, seed[14:8]});
    u_pm.mem[{3'h1, seed[14:8]}] = wt;
    put(0, iex_pkg::OP_SETM, {3'h0, m});
    put(1, iex_pkg::OP_INC_SKIP_ZERO_TO_ACC, {3'h0, m});
    put(2, iex_pkg::OP_MOVAX, 10'h011);
    put(3, iex_pkg::OP_CLRB, {3'h0, m});
    put(4, iex_pkg::OP_DEC_SKIP_ZERO_TO_ACC, {3'h0, m});
    put(5, iex_pkg::OP_NIBBLE_EXCHANGE_TO_ACC, {3'h0, m});
    put(6, iex_pkg::OP_TBRC, {3'h0, m});
    put(7, iex_pkg::OP_CALL, 10'd20);
    put(8, iex_pkg::OP_CLRM, {3'h0, m2});
    put(9, iex_pkg::OP_HALT, 10'h000);
    put(20, iex_pkg::OP_RETURN_FROM_INTERRUPT, 10'h000);
    run(14);
    bus(1'b0, iex_pkg::REG_ACC, 32'h0);
    check("acc_ops", rd, 32'hEF);
    check("table_cur", dut.u_dmem.mem[m], wt[7:0]);
    check("byte_clr", dut.u_dmem.mem[m2], 8'h00);
    bus(1'b0, iex_pkg::REG_TABLE_HIGH_LATCH, 32'h0);
    check("table_cur_high", rd, {25'h0, wt[14:8]});
    // Watchdog pre-clear pair broken, kept, and the single clear, each after a power-down.
    for (int k = 0; k < 3; k++) begin
      boot();
      put(0, iex_pkg::OP_HALT, 10'h000);
      put(1, iex_pkg::OP_WDT, {8'h0, k == 2 ? iex_pkg::WDT_SINGLE : iex_pkg::WDT_FIRST});
      put(2, k == 1 ? iex_pkg::OP_WDT : iex_pkg::OP_NOP, {8'h0, iex_pkg::WDT_SECOND});
      put(3, k == 0 ? iex_pkg::OP_WDT : iex_pkg::OP_NOP, {8'h0, iex_pkg::WDT_SECOND});
      put(4, iex_pkg::OP_CALL, 10'd10);
      put(5, iex_pkg::OP_JMP, 10'd5);
      put(10, iex_pkg::OP_RETAX, {2'h0, seed[7:0]});
      run(1);
      bus(1'b1, iex_pkg::REG_CTRL, 32'h3);
      for (int i = 0; i < 50 && pm_addr !== 10'd5; i++) begin
        @(posedge mclk_i);
      end
      repeat (2) @(posedge mclk_i);
      check("woken", halted, 1'b0);
      check("jump_loop", pm_addr, 10'd5);
      bus(1'b0, iex_pkg::REG_STATUS, 32'h0);
      check("pair_pdf", rd[2], k == 0);
      bus(1'b0, iex_pkg::REG_ACC, 32'h0);
      check("ret_imm", rd, {24'h0, seed[7:0]});
    end
    stop_test();
  end
endmodule
